// ---- core/asrc_ctrl.sv ----
// Controller driving an asynchronous 512K x 8 static memory over its pins
// Function
// - Never drive the shared bus while the memory may still drive it.
// - With output enable held low, write pulse covers overlap plus float time.
// - Write overlap lasts at least 40 or 50 ns by grade.
// - Select held from its fall to write end at least 50 or 60 ns.
// - Address stable until write end at least 50 or 60 ns.
// - Write data valid at least 25 or 30 ns before write end.
// - Retention may begin immediately after deselect.
// - After retention, wait one read cycle time before any access.
`include "asrc_params.svh"
module asrc_ctrl
  import asrc_pkg::*;
#(
  parameter int ADDR_W = `ASRC_ADDR_W,
  parameter int DATA_W = `ASRC_DATA_W,
  parameter int WRITE_CYC = `ASRC_WRITE_CYC,
  parameter int FLOAT_CYC = `ASRC_FLOAT_CYC,
  parameter int READ_CYC = `ASRC_READ_CYC,
  parameter int CYCLE_CYC = `ASRC_CYCLE_CYC,
  parameter int RECOVER_CYC = `ASRC_RECOVER_CYC
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [DATA_W-1:0] req_wdata,
  input wire logic retain_req,
  output logic req_ready,
  output logic rd_valid,
  output logic [DATA_W-1:0] rd_data,
  output logic retained,
  output logic [ADDR_W-1:0] word_address,
  output logic select_b,
  output logic write_b,
  output logic out_en_b,
  input wire logic [DATA_W-1:0] shared_byte_bus_in,
  output logic [DATA_W-1:0] shared_byte_bus_out,
  output logic shared_byte_bus_oe_b
);

  // Refuse settings the sequencer cannot serve; counters reach 256 cycles at most
  if (ADDR_W != `ASRC_ADDR_W || DATA_W != `ASRC_DATA_W) begin : g_bad_width
    $error("asrc_ctrl: address and data widths are fixed by the memory");
  end
  if (WRITE_CYC < 1 || WRITE_CYC > 256) begin : g_bad_write
    $error("asrc_ctrl: write pulse count out of range");
  end
  if (FLOAT_CYC < 1 || FLOAT_CYC > 256) begin : g_bad_float
    $error("asrc_ctrl: float gap count out of range");
  end
  if (READ_CYC < 1 || READ_CYC > 256) begin : g_bad_read
    $error("asrc_ctrl: read access count out of range");
  end
  if (CYCLE_CYC < 1 || CYCLE_CYC > 256) begin : g_bad_cycle
    $error("asrc_ctrl: cycle time count out of range");
  end
  if (RECOVER_CYC < 1 || RECOVER_CYC > 256) begin : g_bad_recover
    $error("asrc_ctrl: recovery count out of range");
  end

  // Eight bit counters cover every default count with room to spare
  localparam int CNT_W = 8;

  asrc_state_t state_q;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cyc_q;
  logic ready_w;

  // A new access waits for idle and for the previous cycle time to elapse
  // Retention also blocks launches so select stays high throughout
  assign ready_w = (state_q == ASRC_IDLE) && (cyc_q == '0) && !retain_req;

  // Sequencer; write timing with output enable kept high so memory never drives
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ASRC_IDLE;
      cnt_q <= '0;
    end else begin
      case (state_q)
        ASRC_IDLE: begin
          // Retention wins over a waiting request
          if (retain_req) begin
            state_q <= ASRC_RETN;
          end else if (req_valid && ready_w) begin
            state_q <= req_write ? ASRC_WSET : ASRC_RACC;
            cnt_q <= req_write ? CNT_W'(WRITE_CYC - 1) : CNT_W'(READ_CYC - 1);
          end
        end
        ASRC_WSET: begin
          state_q <= ASRC_WPUL;
        end
        ASRC_WPUL: begin
          if (cnt_q == '0) begin
            state_q <= ASRC_WEND;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        ASRC_WEND: begin
          // Select rises one cycle after write strobe, so the write ends on write_b
          state_q <= ASRC_IDLE;
        end
        ASRC_RACC: begin
          if (cnt_q == '0) begin
            state_q <= ASRC_RGAP;
            cnt_q <= CNT_W'(FLOAT_CYC - 1);
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        ASRC_RGAP: begin
          // Memory may still drive after output disable
          if (cnt_q == '0) begin
            state_q <= ASRC_IDLE;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        ASRC_RETN: begin
          // Select stays high; the memory ignores every other pin here
          if (!retain_req) begin
            state_q <= ASRC_RCOV;
            cnt_q <= CNT_W'(RECOVER_CYC - 1);
          end
        end
        ASRC_RCOV: begin
          // A full read cycle time passes before the next select
          if (cnt_q == '0) begin
            state_q <= ASRC_IDLE;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        default: begin
          state_q <= ASRC_IDLE;
        end
      endcase
    end
  end

  // Cycle time counter started at each access launch
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cyc_q <= '0;
    end else if (state_q == ASRC_IDLE && req_valid && ready_w) begin
      cyc_q <= CNT_W'(CYCLE_CYC - 1);
    end else if (cyc_q != '0) begin
      cyc_q <= cyc_q - 1'b1;
    end
  end

  // Address and write data latched at launch, held through the write end
  // Holding them until select rise gives address and data hold at least one cycle of margin after write_b rises
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      word_address <= '0;
      shared_byte_bus_out <= '0;
    end else if (state_q == ASRC_IDLE && req_valid && ready_w) begin
      word_address <= req_addr;
      shared_byte_bus_out <= req_wdata;
    end
  end

  // Pin strobes; select drops one cycle before write strobe
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      select_b <= 1'b1;
      write_b <= 1'b1;
      out_en_b <= 1'b1;
      shared_byte_bus_oe_b <= 1'b1;
    end else begin
      select_b <= !(state_q == ASRC_IDLE && req_valid && ready_w) &&
                  !(state_q inside {ASRC_WSET, ASRC_WPUL, ASRC_RACC});
      write_b <= !(state_q == ASRC_WSET) && !(state_q == ASRC_WPUL && cnt_q != '0);
      out_en_b <= !(state_q == ASRC_IDLE && req_valid && ready_w && !req_write) &&
                  !(state_q == ASRC_RACC && cnt_q != '0);
      // Drive data only while out_en_b is high and a write is framed
      shared_byte_bus_oe_b <= !(state_q == ASRC_IDLE && req_valid && ready_w &&
                                req_write) && !(state_q inside {ASRC_WSET, ASRC_WPUL});
    end
  end

  // Sample read data on the last access cycle, after access time
  // Output enable rises at the sampling edge itself, so the byte is still driven
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rd_valid <= 1'b0;
      rd_data <= '0;
    end else begin
      rd_valid <= (state_q == ASRC_RACC && cnt_q == '0);
      if (state_q == ASRC_RACC && cnt_q == '0) begin
        rd_data <= shared_byte_bus_in;
      end
    end
  end

  // Status outputs registered
  // req_ready drops after a take so a held request is not launched twice
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      req_ready <= 1'b0;
      retained <= 1'b0;
    end else begin
      req_ready <= ready_w && !(req_valid && req_ready);
      retained <= (state_q == ASRC_RETN);
    end
  end

endmodule : asrc_ctrl

// ---- core/asrc_params.svh ----
// Timing figures and cycle counts for the static memory controller
`ifndef ASRC_PARAMS_SVH
`define ASRC_PARAMS_SVH
`define ASRC_CLK_PERIOD_NS 50
// Slow grade figures in ns, the safer default
`define ASRC_WRITE_PULSE_MIN_NS 50
`define ASRC_SELECT_TO_WRITE_END_MIN_NS 60
`define ASRC_ADDRESS_TO_WRITE_END_MIN_NS 60
`define ASRC_DATA_OVERLAP_MIN_NS 30
`define ASRC_WRITE_TO_FLOAT_MAX_NS 25
`define ASRC_DISABLE_TO_FLOAT_MAX_NS 25
`define ASRC_READ_CYCLE_MIN_NS 70
`define ASRC_ACCESS_MAX_NS 70
`define ASRC_DESELECT_TO_RETAIN_MIN_NS 0
// Least times round up to whole cycles, never below one
`define ASRC_CYC_UP(ns) (((ns) + `ASRC_CLK_PERIOD_NS - 1) / `ASRC_CLK_PERIOD_NS)
`define ASRC_MAX1(x) (((x) < 1) ? 1 : (x))
`define ASRC_WP_FIXED_NS (`ASRC_DATA_OVERLAP_MIN_NS + `ASRC_WRITE_TO_FLOAT_MAX_NS)
`define ASRC_WP_NS ((`ASRC_WP_FIXED_NS > `ASRC_SELECT_TO_WRITE_END_MIN_NS) ? \
  `ASRC_WP_FIXED_NS : `ASRC_SELECT_TO_WRITE_END_MIN_NS)
`define ASRC_WRITE_CYC `ASRC_MAX1(`ASRC_CYC_UP(`ASRC_WP_NS))
`define ASRC_FLOAT_CYC `ASRC_MAX1(`ASRC_CYC_UP(`ASRC_DISABLE_TO_FLOAT_MAX_NS))
`define ASRC_READ_CYC `ASRC_MAX1(`ASRC_CYC_UP(`ASRC_ACCESS_MAX_NS))
`define ASRC_CYCLE_CYC `ASRC_MAX1(`ASRC_CYC_UP(`ASRC_READ_CYCLE_MIN_NS))
`define ASRC_RECOVER_CYC `ASRC_CYCLE_CYC
`define ASRC_ADDR_W 19
`define ASRC_DATA_W 8
`endif

// ---- core/asrc_pkg.sv ----
// Types for the static memory controller
package asrc_pkg;
  typedef enum logic [2:0] {
    ASRC_IDLE = 3'b000,
    ASRC_WSET = 3'b001,
    ASRC_WPUL = 3'b010,
    ASRC_WEND = 3'b011,
    ASRC_RACC = 3'b100,
    ASRC_RGAP = 3'b101,
    ASRC_RETN = 3'b110,
    ASRC_RCOV = 3'b111
  } asrc_state_t;
endpackage : asrc_pkg

// ---- tb/asrc_properties.sv ----
// Pin timing checker for the static memory controller
module asrc_properties #(parameter int ADDR_W = 19, parameter int DATA_W = 8) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic rd_valid,
  input wire logic retained,
  input wire logic [ADDR_W-1:0] word_address,
  input wire logic select_b,
  input wire logic write_b,
  input wire logic out_en_b,
  input wire logic [DATA_W-1:0] shared_byte_bus_out,
  input wire logic shared_byte_bus_oe_b
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  property p_clash; !shared_byte_bus_oe_b |-> out_en_b; endproperty
  a_clash: assert property (p_clash) else $error("bus driven into enabled output");
  property p_oeh; !write_b |-> out_en_b; endproperty
  a_oeh: assert property (p_oeh) else $error("output enable low in write");
  property p_wp; $fell(write_b) |-> (!write_b && !select_b) [*2]; endproperty
  a_wp: assert property (p_wp) else $error("write pulse short");
  property p_cs; $fell(select_b) |-> !select_b [*2]; endproperty
  a_cs: assert property (p_cs) else $error("select pulse short");
  property p_adr; !select_b && !$past(select_b) |-> $stable(word_address); endproperty
  a_adr: assert property (p_adr) else $error("address moved");
  property p_dat; !write_b |-> !shared_byte_bus_oe_b && $stable(shared_byte_bus_out); endproperty
  a_dat: assert property (p_dat) else $error("write data not held");
  property p_ret; retained |-> select_b [*3]; endproperty
  a_ret: assert property (p_ret) else $error("access too soon after retention");
  property p_rd; $fell(select_b) && !out_en_b |-> ##2 rd_valid; endproperty
  a_rd: assert property (p_rd) else $error("read result late");
  property p_gap; $rose(select_b) |-> !$past(select_b, 2); endproperty
  a_gap: assert property (p_gap) else $error("cycle too short");
  cover property ($fell(write_b));
  cover property (rd_valid);
  cover property ($rose(retained));
endmodule : asrc_properties
bind asrc_ctrl asrc_properties #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) i_asrc_properties (
  .mclk(mclk),
  .rst_b(rst_b),
  .rd_valid(rd_valid),
  .retained(retained),
  .word_address(word_address),
  .select_b(select_b),
  .write_b(write_b),
  .out_en_b(out_en_b),
  .shared_byte_bus_out(shared_byte_bus_out),
  .shared_byte_bus_oe_b(shared_byte_bus_oe_b)
);

// ---- tb/asrc_sram_model.sv ----
// Behavioural 512K x 8 asynchronous static memory
module asrc_sram_model (
  input wire logic [18:0] word_address,
  input wire logic select_b,
  input wire logic write_b,
  input wire logic out_en_b,
  input wire logic [7:0] bus_in,
  output logic [7:0] bus_out,
  output logic drive
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [int];
  logic wr_open = 1'b0;
  // Overlap of both strobes low, no clock involved
  wire wr_act = !select_b && !write_b;
  // Store only when a real overlap closes; the unknown-to-low step at reset is no write
  always @(wr_act or word_address) begin
    if (wr_act === 1'b1) begin
      wr_open = 1'b1;
    end else if (wr_open) begin
      mem[word_address] = bus_in;
      wr_open = 1'b0;
    end
    bus_out = mem.exists(word_address) ? mem[word_address] : 8'h00;
  end
  // Drive only a plain read; a write keeps pins floating
  always_comb drive = !select_b && !out_en_b && write_b;
endmodule : asrc_sram_model

// ---- tb/tb.sv ----
// Self-checking bench for the static memory controller
`include "asrc_params.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0, rst_b = 1'b0, req_valid = 1'b0, req_write = 1'b0, retain_req = 1'b0;
  logic [18:0] req_addr = 19'h0, word_address, a;
  logic [7:0] req_wdata = 8'h0, rd_data, c_out, m_out, last = 8'h00;
  logic req_ready, rd_valid, retained, select_b, write_b, out_en_b, oe_b, drive;
  logic [7:0] ref_m [int];
  int miscompares = 0, compares = 0, cyc = 0;
  // Released bus shows the inverse of its last value
  wire [7:0] bus = !oe_b ? c_out : drive ? m_out : ~last;
  always #25 mclk = ~mclk;
  always @(posedge mclk) last <= bus;
  asrc_ctrl i_asrc_ctrl (.mclk, .rst_b, .req_valid, .req_write, .req_addr, .req_wdata,
    .retain_req, .req_ready, .rd_valid, .rd_data, .retained, .word_address, .select_b,
    .write_b, .out_en_b, .shared_byte_bus_in(bus), .shared_byte_bus_out(c_out),
    .shared_byte_bus_oe_b(oe_b));
  asrc_sram_model i_asrc_sram_model (.word_address, .select_b, .write_b, .out_en_b,
    .bus_in(bus), .bus_out(m_out), .drive);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish
  // One request, held for one taking edge once ready
  task automatic op(input logic w, input logic [18:0] ad, input logic [7:0] d);
    int n;
    n = 0;
    do @(posedge mclk); while (req_ready !== 1'b1);
    req_valid <= 1'b1;
    req_write <= w;
    req_addr <= ad;
    req_wdata <= d;
    @(posedge mclk);
    req_valid <= 1'b0;
    if (w) ref_m[ad] = d;
    else begin
      while (rd_valid !== 1'b1 && n < 20) begin
        @(posedge mclk);
        n++;
      end
      chk(n, `ASRC_READ_CYC + 1);
      chk(rd_data, ref_m.exists(ad) ? ref_m[ad] : 8'h00);
    end
  endtask : op
  // Cycle ceiling cuts a hang short
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  initial begin
    void'($urandom(32'h258d));
    repeat (8) @(posedge mclk);
    rst_b <= 1'b1;
    // Boundary and random addresses, back to back
    for (int i = 0; i < 12; i++) begin
      a = (i == 0) ? 19'h0 : (i == 1) ? 19'h7ffff : 19'($urandom);
      op(1'b1, a, 8'($urandom));
      op(1'b0, a, 8'h00);
      op(1'b0, a ^ 19'h1, 8'h00);
    end
    $display("test write_read done");
    a = 19'h7ffff;
    retain_req <= 1'b1;
    req_valid <= 1'b1;
    repeat (6) @(posedge mclk);
    chk(retained, 1);
    chk(select_b, 1);
    retain_req <= 1'b0;
    req_valid <= 1'b0;
    op(1'b0, a, 8'h00);
    $display("test retention done");
    tally_and_finish();
  end
endmodule : tb
